// >>> src/central_memory_frame_switch.sv
// Eight-port central-memory frame switch with inter-port message link and
// a double-buffered firmware frame port. Serializer symbols are pins from
// another clock domain and are synchronised; firmware pins are same-clock.
`timescale 1ns/10ps
`include "cmfs_map.svh"
module central_memory_frame_switch import cmfs_pkg::*; (
  // Clock and synchronous reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Serializer channels and buffer mode strap
  input  wire sym_t        [7:0] i_rx_sym,
  input  wire logic              i_mini_mode,
  output sym_t             [7:0] o_tx_sym,
  output logic             [7:0] o_rx_ready,
  // Firmware frame access port
  input  wire logic              i_fw_rd,
  input  wire logic              i_fw_wr,
  input  wire logic       [11:0] i_fw_addr,
  input  wire logic       [31:0] i_fw_wdata,
  input  wire logic              i_fw_swap,
  output logic            [31:0] o_fw_rdata,
  output logic                   o_fw_rpar,
  output logic                   o_fw_rvalid,
  output logic                   o_fw_ready,
  output logic            [11:0] o_fw_len
);
  localparam int NP = `NPORTS;
  localparam int NB = `BUF_SLOTS;

  // Central memory address: own region per port, buffer, then offset
  function automatic logic [15:0] cm_addr_f(input logic [2:0] port, input logic [3:0] bn,
                                            input logic [11:0] off, input logic mini);
    logic [15:0] bsz;
    bsz = mini ? `MINI_BYTES : `FULL_BYTES;
    return 16'(port) * `PORT_WORDS + 16'(bn) * bsz + 16'(off);
  endfunction : cm_addr_f

  // Time-slice counter shared by memory and message link
  logic [2:0] slot_q;                  // Port owning this cycle
  logic [2:0] slot_prev_q;             // Owner of the read now returning
  logic       mini_s1_q, mini_s2_q;    // Strap synchroniser
  logic       mini_q;                  // Mode caught during reset

  always_ff @(posedge i_clk_sys) begin
    mini_s1_q   <= i_mini_mode;
    mini_s2_q   <= mini_s1_q;
    slot_prev_q <= slot_q;
    if (i_rst) begin
      slot_q <= 3'h0;
      mini_q <= mini_s2_q;             // Mode only changes under reset
    end else begin
      slot_q <= slot_q + 3'h1;
    end
  end

  // Buffer geometry follows the strap
  wire [11:0] bufsz = mini_q ? 12'(`MINI_BYTES) : 12'(`FULL_BYTES);
  wire [4:0]  nbufs = mini_q ? `MINI_BUFS : `FULL_BUFS;

  // Per-port state, indexed by port number
  sym_t       rx_s1_q  [NP];           // First synchroniser stage
  sym_t       rx_s2_q  [NP];           // Second synchroniser stage
  sym_t       hold_q   [NP];           // Symbol waiting for its slot
  rx_state_t  rx_st_q  [NP];
  logic [3:0] cur_buf_q[NP];           // Buffer being written
  logic [11:0] cur_len_q[NP];          // Words written so far
  logic [7:0] busy_q   [NP][NB];       // Outstanding destinations per buffer
  logic [7:0] put_pend_q[NP];          // Routing requests still to send
  logic [127:0] pend_q [NP];           // Transmit queue, bit = src*16+buf
  logic       tx_act_q [NP];
  logic [2:0] tx_src_q [NP];
  logic [3:0] tx_buf_q [NP];
  logic [11:0] tx_off_q[NP];
  logic       wait_full_q[NP];         // Busy start: wait for whole frame
  logic       idle_arr_q[NP];          // Request arrived at an idle port
  logic       rd_v_q   [NP];           // Read issued last cycle
  logic       fin_v_q  [NP];           // Completion queued
  logic       fin_rdy_q[NP];           // Completion may leave
  logic [2:0] fin_src_q[NP];
  logic [3:0] fin_buf_q[NP];
  sym_t       tx_sym_q [NP];
  logic       rdy_q    [NP];

  // Per-port outputs of the combinational slices
  msg_t        msg_out [NP];
  msg_t        msg_in  [NP];
  logic        cm_we_w [NP];
  logic [15:0] cm_wa_w [NP];
  sym_t        cm_wd_w [NP];
  logic [15:0] cm_ra_w [NP];
  logic        cap_we_w[NP];
  logic        cap_go_w[NP];
  logic        cap_end_w[NP];

  // Firmware buffer state
  logic        fw_dev_q;               // Buffer the device streams into
  logic        fw_full_q;              // Device buffer holds a whole frame
  logic        fw_lock_q;              // Capture in progress
  logic [11:0] fw_off_q;
  logic [11:0] cap_len_q;
  logic        fw_rv_q;
  logic [9:0]  fw_rdata;
  logic [9:0]  cm_rdata;

  wire cap_ok = !fw_full_q && !fw_lock_q;

  // Central memory: one write and one read per cycle, by slot owner
  dp_ram #(.W(10), .DEPTH(`CM_WORDS), .AW(16)) u_cm (
    .i_clk_sys (i_clk_sys),
    .i_a_we    (cm_we_w[slot_q]),
    .i_a_addr  (cm_wa_w[slot_q]),
    .i_a_wdata (cm_wd_w[slot_q]),
    .i_b_we    (1'b0),
    .i_b_addr  (cm_ra_w[slot_q]),
    .i_b_wdata (10'h000),
    .o_b_rdata (cm_rdata)
  );

  // Firmware buffers: device side on A, firmware side on B
  wire [12:0] fw_cap_a = (fw_dev_q ? `FW_BUF_WORDS : 13'h0000)
                         + 13'(cap_go_w[slot_q] ? 12'h000 : fw_off_q);
  wire [12:0] fw_own_a = (fw_dev_q ? 13'h0000 : `FW_BUF_WORDS) + 13'(i_fw_addr);
  dp_ram #(.W(10), .DEPTH(`FW_WORDS), .AW(13)) u_fw (
    .i_clk_sys (i_clk_sys),
    .i_a_we    (cap_we_w[slot_q]),
    .i_a_addr  (fw_cap_a),
    .i_a_wdata (hold_q[slot_q]),
    .i_b_we    (i_fw_wr),
    .i_b_addr  (fw_own_a),
    .i_b_wdata (i_fw_wdata[9:0]),
    .o_b_rdata (fw_rdata)
  );

  for (genvar p = 0; p < NP; p++) begin : g_port
    wire [2:0] dst    = 3'(p) + slot_q;         // Destination of this slot
    wire [2:0] src_in = 3'(p) - slot_q;         // Sender heard this slot
    wire       go     = slot_q == 3'(p) && hold_q[p].kind != `SYM_IDLE;
    wire       is_sof = hold_q[p].kind == `SYM_SOF;
    wire       is_eof = hold_q[p].kind == `SYM_EOF;
    wire [NB-1:0] free_v;
    wire [3:0] free_idx;
    wire       free_any;
    wire [6:0] pk_idx;
    wire       pk_any;

    // A buffer is free only with no destination outstanding
    for (genvar b = 0; b < NB; b++) begin : g_free
      assign free_v[b] = 5'(b) < nbufs && busy_q[p][b] == 8'h00
                         && !(rx_st_q[p] == RX_STORE && cur_buf_q[p] == 4'(b));
    end
    first_one #(.W(NB), .IW(4)) u_free (
      .i_vec (free_v),
      .o_idx (free_idx),
      .o_any (free_any)
    );
    first_one #(.W(128), .IW(7)) u_pick (
      .i_vec (pend_q[p]),
      .o_idx (pk_idx),
      .o_any (pk_any)
    );

    // Receive decisions for this port's slot
    wire hdr_nz    = hold_q[p].data != 8'h00;
    wire sof_store = go && is_sof && hdr_nz && free_any;
    wire st_store  = go && !is_sof && rx_st_q[p] == RX_STORE;
    wire trunc     = st_store && cur_len_q[p] == bufsz - 12'h001;
    assign cm_we_w[p]  = sof_store || st_store;
    assign cm_wa_w[p]  = cm_addr_f(3'(p), sof_store ? free_idx : cur_buf_q[p],
                                   sof_store ? 12'h000 : cur_len_q[p], mini_q);
    assign cm_wd_w[p]  = trunc ? {`SYM_EOF, hold_q[p].data} : hold_q[p];
    assign cap_go_w[p] = go && is_sof && !hdr_nz && cap_ok;
    assign cap_we_w[p] = cap_go_w[p] || (go && !is_sof && rx_st_q[p] == RX_CAPT);
    assign cap_end_w[p] = go && is_eof && rx_st_q[p] == RX_CAPT;

    // Outgoing message: only for this slot's destination, else all zero
    assign msg_out[p].put_v   = put_pend_q[p][dst];
    assign msg_out[p].put_buf = put_pend_q[p][dst] ? cur_buf_q[p] : 4'h0;
    assign msg_out[p].fin_v   = fin_v_q[p] && fin_rdy_q[p] && fin_src_q[p] == dst;
    assign msg_out[p].fin_buf = msg_out[p].fin_v ? fin_buf_q[p] : 4'h0;
    assign msg_in[p]          = msg_out[src_in];

    // Transmit read gating: idle start cuts through, busy start waits
    wire wr_live = rx_st_q[tx_src_q[p]] == RX_STORE && cur_buf_q[tx_src_q[p]] == tx_buf_q[p];
    wire can_rd  = tx_act_q[p] && slot_q == 3'(p) && (!wr_live
                   || (!wait_full_q[p] && tx_off_q[p] < cur_len_q[tx_src_q[p]]));
    wire deq     = !tx_act_q[p] && !fin_v_q[p] && pk_any;
    wire ret     = rd_v_q[p] && slot_prev_q == 3'(p);
    assign cm_ra_w[p] = cm_addr_f(tx_src_q[p], tx_buf_q[p], tx_off_q[p], mini_q);

    // Pin synchroniser and slot holding register
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        rx_s1_q[p] <= '0;
        rx_s2_q[p] <= '0;
        hold_q[p]  <= '0;
      end else begin
        rx_s1_q[p] <= i_rx_sym[p];
        rx_s2_q[p] <= rx_s1_q[p];
        if (rx_s2_q[p].kind != `SYM_IDLE) begin
          hold_q[p] <= rx_s2_q[p];                         // New symbol wins
        end else if (slot_q == 3'(p)) begin
          hold_q[p] <= '0;                                 // Consumed in slot
        end
      end
    end

    // Receive side: buffer ownership, requests, completions
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        rx_st_q[p]    <= RX_IDLE;
        cur_buf_q[p]  <= 4'h0;
        cur_len_q[p]  <= 12'h000;
        put_pend_q[p] <= 8'h00;
        rdy_q[p]      <= 1'b0;
        for (int b = 0; b < NB; b++) begin
          busy_q[p][b] <= 8'h00;
        end
      end else begin
        rdy_q[p] <= free_any;
        // Completion from one destination clears only its bit
        if (msg_in[p].fin_v) begin
          busy_q[p][msg_in[p].fin_buf][src_in] <= 1'b0;
        end
        if (put_pend_q[p][dst]) begin
          put_pend_q[p][dst] <= 1'b0;
        end
        if (go) begin
          if (is_sof) begin
            if (sof_store) begin
              rx_st_q[p]           <= RX_STORE;
              cur_buf_q[p]         <= free_idx;
              cur_len_q[p]         <= 12'h001;
              busy_q[p][free_idx]  <= hold_q[p].data;
              put_pend_q[p]        <= hold_q[p].data;
            end else if (cap_go_w[p]) begin
              rx_st_q[p] <= RX_CAPT;
            end else begin
              rx_st_q[p] <= RX_DROP;
            end
          end else if (is_eof) begin
            rx_st_q[p] <= RX_IDLE;
            if (st_store) begin
              cur_len_q[p] <= cur_len_q[p] + 12'h001;
            end
          end else if (st_store) begin
            cur_len_q[p] <= cur_len_q[p] + 12'h001;
            if (trunc) begin
              rx_st_q[p] <= RX_DROP;                       // Oversize: cut off
            end
          end
        end
      end
    end

    // Destination side: queue, memory fetch, completion message
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        pend_q[p]      <= '0;
        tx_act_q[p]    <= 1'b0;
        tx_src_q[p]    <= 3'h0;
        tx_buf_q[p]    <= 4'h0;
        tx_off_q[p]    <= 12'h000;
        wait_full_q[p] <= 1'b0;
        idle_arr_q[p]  <= 1'b0;
        rd_v_q[p]      <= 1'b0;
        fin_v_q[p]     <= 1'b0;
        fin_rdy_q[p]   <= 1'b0;
        fin_src_q[p]   <= 3'h0;
        fin_buf_q[p]   <= 4'h0;
        tx_sym_q[p]    <= '0;
      end else begin
        rd_v_q[p]   <= can_rd;
        tx_sym_q[p] <= '0;                                 // Symbol lasts one cycle
        if (deq) begin
          // Entry leaves the queue before transmission starts
          pend_q[p][pk_idx] <= 1'b0;
          tx_act_q[p]    <= 1'b1;
          tx_src_q[p]    <= pk_idx[6:4];
          tx_buf_q[p]    <= pk_idx[3:0];
          tx_off_q[p]    <= 12'h000;
          wait_full_q[p] <= !idle_arr_q[p];
          idle_arr_q[p]  <= 1'b0;
          fin_v_q[p]     <= 1'b1;
          fin_rdy_q[p]   <= 1'b0;
          fin_src_q[p]   <= pk_idx[6:4];
          fin_buf_q[p]   <= pk_idx[3:0];
        end
        if (msg_in[p].put_v) begin
          pend_q[p][{src_in, msg_in[p].put_buf}] <= 1'b1;
          if (!tx_act_q[p] && !pk_any) begin
            idle_arr_q[p] <= 1'b1;
          end
        end
        if (can_rd) begin
          tx_off_q[p] <= tx_off_q[p] + 12'h001;
        end
        if (ret) begin
          tx_sym_q[p] <= cm_rdata;
          if (cm_rdata[9:8] == `SYM_EOF) begin
            // Release held until the last word left the buffer
            tx_act_q[p]  <= 1'b0;
            fin_rdy_q[p] <= 1'b1;
          end
        end
        if (msg_out[p].fin_v) begin
          fin_v_q[p] <= 1'b0;
        end
      end
    end

    assign o_tx_sym[p]   = tx_sym_q[p];
    assign o_rx_ready[p] = rdy_q[p];
  end

  // Firmware buffer ownership and capture bookkeeping
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fw_dev_q    <= 1'b0;
      fw_full_q   <= 1'b0;
      fw_lock_q   <= 1'b0;
      fw_off_q    <= 12'h000;
      cap_len_q   <= 12'h000;
      o_fw_len    <= 12'h000;
      fw_rv_q     <= 1'b0;
      o_fw_rvalid <= 1'b0;
      o_fw_rdata  <= 32'h0000_0000;
      o_fw_rpar   <= 1'b0;
      o_fw_ready  <= 1'b0;
    end else begin
      fw_rv_q     <= i_fw_rd;
      o_fw_rvalid <= fw_rv_q;
      o_fw_rdata  <= {22'h000000, fw_rdata};
      o_fw_rpar   <= ^fw_rdata;
      o_fw_ready  <= fw_full_q;
      if (cap_go_w[slot_q]) begin
        fw_lock_q <= 1'b1;
        fw_off_q  <= 12'h001;
      end else if (cap_we_w[slot_q] && fw_off_q != 12'(`FW_BUF_WORDS) - 12'h001) begin
        fw_off_q  <= fw_off_q + 12'h001;                   // Oversize stops at end
      end
      if (cap_end_w[slot_q]) begin
        fw_lock_q <= 1'b0;
        fw_full_q <= 1'b1;
        cap_len_q <= fw_off_q + 12'h001;
      end
      // Swap hands the filled buffer to firmware, the other to capture
      if (i_fw_swap && !fw_lock_q && !cap_go_w[slot_q]) begin
        fw_dev_q  <= ~fw_dev_q;
        fw_full_q <= 1'b0;
        o_fw_len  <= fw_full_q ? cap_len_q : 12'h000;
      end
    end
  end
endmodule : central_memory_frame_switch

// >>> src/cmfs_map.svh
// Constants of the central-memory frame switch: sizes, encodings, counts.
// Assumes a single 100 MHz system clock; included by the design files.
`ifndef CMFS_MAP_SVH
`define CMFS_MAP_SVH

`define NPORTS       8
`define BUF_SLOTS    16
`define FULL_BYTES   16'h0840
`define MINI_BYTES   16'h0138
`define FULL_BUFS    5'h02
`define MINI_BUFS    5'h0d
`define PORT_WORDS   16'h1080
`define CM_WORDS     33792
`define FW_BUF_WORDS 13'h0840
`define FW_WORDS     4224
`define SYM_IDLE     2'h0
`define SYM_SOF      2'h1
`define SYM_DATA     2'h2
`define SYM_EOF      2'h3

`endif

// >>> src/cmfs_pkg.sv
// Types shared by the frame switch: symbols, link messages, receive states.
// Assumes the constants header is included by the modules that use it.
package cmfs_pkg;

  // One 10-bit serializer symbol: kind in the top two bits, byte below
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] data;
  } sym_t;

  // One slot of the inter-port message link; all zero means no message
  typedef struct packed {
    logic       put_v;
    logic [3:0] put_buf;
    logic       fin_v;
    logic [3:0] fin_buf;
  } msg_t;

  // Receive side of one port
  typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_CAPT, RX_DROP} rx_state_t;

endpackage : cmfs_pkg

// >>> src/dp_ram.sv
// Simple two-port RAM: port A writes only, port B writes or reads.
// Read data come out of a register one cycle after the address.
`timescale 1ns/10ps
module dp_ram #(
  parameter int W     = 10,
  parameter int DEPTH = 4224,
  parameter int AW    = 13
) (
  // Clock
  input  wire logic          i_clk_sys,
  // Write-only port
  input  wire logic          i_a_we,
  input  wire logic [AW-1:0] i_a_addr,
  input  wire logic [W-1:0]  i_a_wdata,
  // Read/write port
  input  wire logic          i_b_we,
  input  wire logic [AW-1:0] i_b_addr,
  input  wire logic [W-1:0]  i_b_wdata,
  output logic      [W-1:0]  o_b_rdata
);
  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
    $error("dp_ram: depth does not fit address");
  end

  logic [W-1:0] mem [DEPTH];   // Storage, no reset on purpose

  // Both ports; callers keep them on different words
  always_ff @(posedge i_clk_sys) begin
    if (i_a_we) begin
      mem[i_a_addr] <= i_a_wdata;
    end
    if (i_b_we) begin
      mem[i_b_addr] <= i_b_wdata;
    end
    o_b_rdata <= mem[i_b_addr];
  end
endmodule : dp_ram

// >>> src/first_one.sv
// Lowest-set-bit picker used for free-buffer and transmit-queue choice.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/10ps
module first_one #(
  parameter int W  = 16,
  parameter int IW = 4
) (
  // Request vector
  input  wire logic [W-1:0]  i_vec,
  // Chosen index and any-set flag
  output logic      [IW-1:0] o_idx,
  output logic               o_any
);
  if (W > (1 << IW)) begin : g_chk
    $error("first_one: index too narrow");
  end

  // Scan from the top so the lowest set bit wins
  always_comb begin
    o_idx = '0;
    o_any = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (i_vec[i]) begin
        o_idx = IW'(i);
        o_any = 1'b1;
      end
    end
  end
endmodule : first_one

// >>> verification/cmfs_props.sv
// Port checker for the frame switch: reset levels, transmit pacing, reads.
// Assumes one clock domain; bound to the switch top below.
`timescale 1ns/10ps
`include "cmfs_map.svh"
module cmfs_props import cmfs_pkg::*; (
  // Clock and reset
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  // Firmware requests
  input wire logic              i_fw_rd,
  input wire logic              i_fw_swap,
  // Watched outputs
  input wire sym_t        [7:0] o_tx_sym,
  input wire logic        [7:0] o_rx_ready,
  input wire logic       [31:0] o_fw_rdata,
  input wire logic              o_fw_rpar,
  input wire logic              o_fw_rvalid,
  input wire logic       [11:0] o_fw_len
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire  [7:0] tx_live;  // Ports showing a non-idle symbol
  // Read walk: two cycles, then marked data
  sequence rd_walk;
    ##2 o_fw_rvalid;
  endsequence
  // All ports refuse first, then all offer a buffer
  sequence ready_walk;
    o_rx_ready == 8'h00 ##1 o_rx_ready == 8'hff;
  endsequence
  chk_ready_release: assert property ($fell(i_rst) |-> ready_walk)
    else $error("receive ready wrong after reset");
  chk_tx_quiet: assert property ($fell(i_rst) |-> (tx_live == 8'h00) [*4])
    else $error("transmit not idle after reset");
  // One symbol a slot round on each port, header only to its own mask
  for (genvar p = 0; p < 8; p++) begin : g_port
    assign tx_live[p] = (o_tx_sym[p].kind != `SYM_IDLE);
    chk_tx_spacing: assert property (tx_live[p] |=> !tx_live[p] [*7])
      else $error("transmit symbols closer than a slot round");
    chk_header_dest: assert property (o_tx_sym[p].kind == `SYM_SOF |-> o_tx_sym[p].data[p])
      else $error("header sent to port outside its mask");
  end
  chk_rd_answer: assert property (i_fw_rd |-> rd_walk)
    else $error("firmware read not answered in two cycles");
  chk_rd_cause: assert property (o_fw_rvalid |-> $past(i_fw_rd, 2))
    else $error("read data without a request");
  chk_rd_parity: assert property (o_fw_rvalid |-> o_fw_rpar == ^o_fw_rdata[9:0])
    else $error("read parity not even");
  // Length only moves when the buffers trade places
  chk_len_swap: assert property ($changed(o_fw_len) |-> $past(i_fw_swap) || $past(i_fw_swap, 2))
    else $error("frame length moved without a swap");
endmodule : cmfs_props

bind central_memory_frame_switch cmfs_props i_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_fw_rd(i_fw_rd), .i_fw_swap(i_fw_swap),
  .o_tx_sym(o_tx_sym), .o_rx_ready(o_rx_ready), .o_fw_rdata(o_fw_rdata),
  .o_fw_rpar(o_fw_rpar), .o_fw_rvalid(o_fw_rvalid), .o_fw_len(o_fw_len));

// >>> verification/ser_model.sv
// Serializer channel model feeding framed symbols to the receive pins.
// Assumes callers start it on a falling edge; one frame a port at a time.
`timescale 1ns/10ps
`include "cmfs_map.svh"
module ser_model import cmfs_pkg::*; (
  // Clock
  input  wire logic       i_clk_sys,
  // Receive symbols into the switch
  output sym_t      [7:0] o_sym
);
  initial o_sym = '0;
  // Payload byte k of a frame from port p
  function automatic logic [7:0] byte_of(input int p, input int k);
    return 8'(p * 16 + k);
  endfunction : byte_of
  // Header holds the mask, EOF carries the last byte, a symbol each 8 cycles
  task automatic send_frame(input int p, input logic [7:0] mask, input int n);
    for (int k = 0; k <= n; k++) begin
      o_sym[p].kind = (k == 0) ? `SYM_SOF : (k == n) ? `SYM_EOF : `SYM_DATA;
      o_sym[p].data = (k == 0) ? mask : byte_of(p, k);
      @(negedge i_clk_sys);
      // Idle data flips so a stale byte never looks fresh
      o_sym[p].kind = `SYM_IDLE;
      o_sym[p].data = ~o_sym[p].data;
      repeat (7) @(negedge i_clk_sys);
    end
  endtask : send_frame
endmodule : ser_model

// >>> verification/tb_top.sv
// Bench for the frame switch: unicast, multicast, queued, firmware frames.
// Assumes the serializer model and the bound port checker.
`timescale 1ns/10ps
`include "cmfs_map.svh"
module tb_top import cmfs_pkg::*; ();
  logic        i_clk_sys = 1'b0;
  logic        rst       = 1'b1;
  logic        mini_mode = 1'b0;
  logic        fw_rd     = 1'b0;
  logic        fw_wr     = 1'b0;
  logic        fw_swap   = 1'b0;
  logic [11:0] fw_addr   = 12'h000;
  logic [31:0] fw_wdata  = 32'h0000_0000;
  sym_t  [7:0] rx_sym, tx_sym;
  logic  [7:0] rx_ready;
  logic [31:0] fw_rdata;
  logic        fw_rpar, fw_rvalid, fw_ready;
  logic [11:0] fw_len;
  int          n_errors  = 0;
  int          compares  = 0;
  int          cycles    = 0;
  int          rx_done;    // Sender has finished its frame
  sym_t        txq[8][$];  // Symbols seen per transmit port

  initial forever #5 i_clk_sys = ~i_clk_sys;

  ser_model i_ser (.i_clk_sys(i_clk_sys), .o_sym(rx_sym));
  central_memory_frame_switch i_dut (
    .i_clk_sys(i_clk_sys), .i_rst(rst), .i_rx_sym(rx_sym), .i_mini_mode(mini_mode),
    .o_tx_sym(tx_sym), .o_rx_ready(rx_ready), .i_fw_rd(fw_rd), .i_fw_wr(fw_wr),
    .i_fw_addr(fw_addr), .i_fw_wdata(fw_wdata), .i_fw_swap(fw_swap),
    .o_fw_rdata(fw_rdata), .o_fw_rpar(fw_rpar), .o_fw_rvalid(fw_rvalid),
    .o_fw_ready(fw_ready), .o_fw_len(fw_len));

  // Collect transmit symbols; each stands one cycle so is seen once
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    for (int p = 0; p < 8; p++) begin
      if (tx_sym[p].kind !== `SYM_IDLE) begin
        txq[p].push_back(tx_sym[p]);
      end
    end
  end
  // A hang counts as a mismatch
  always @(negedge i_clk_sys) begin
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : chk

  // Word k of a frame as the sender built it
  function automatic sym_t word_of(input int s, input logic [7:0] m, input int n, input int k);
    sym_t w;
    w.kind = (k == 0) ? `SYM_SOF : (k == n) ? `SYM_EOF : `SYM_DATA;
    w.data = (k == 0) ? m : i_ser.byte_of(s, k);
    return w;
  endfunction : word_of

  task automatic expect_frame(input int d, input int s, input logic [7:0] m, input int n,
                              input int at);
    int t = 0;
    while (txq[d].size() < at + n + 1 && t < 800) begin
      @(negedge i_clk_sys);
      t++;
    end
    for (int k = 0; k <= n; k++) begin
      chk(32'(txq[d][at + k]), 32'(word_of(s, m, n, k)), "tx word");
    end
  endtask : expect_frame

  task automatic do_reset(input logic mini);
    @(negedge i_clk_sys);
    rst = 1'b1;
    mini_mode = mini;
    repeat (10) @(negedge i_clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk(32'(rx_ready), 32'hff, "ready after reset");
    foreach (txq[p]) txq[p].delete();
  endtask : do_reset

  // Idle destination starts before the frame is fully stored
  task automatic t_unicast();
    rx_done = 0;
    fork
      begin
        i_ser.send_frame(0, 8'h08, 3);
        rx_done = 1;
      end
    join_none
    expect_frame(3, 0, 8'h08, 0, 0);
    // Header must leave while the sender is still busy with the frame
    chk(32'(rx_done), 32'h0, "no cut-through");
    expect_frame(3, 0, 8'h08, 3, 0);
    repeat (30) @(negedge i_clk_sys);
    chk(32'(rx_ready), 32'hff, "buffer kept");
    chk(32'(txq[3].size()), 32'h4, "extra words");
    $display("test unicast done");
  endtask : t_unicast

  task automatic t_multicast();
    i_ser.send_frame(1, 8'h30, 2);
    expect_frame(4, 1, 8'h30, 2, 0);
    expect_frame(5, 1, 8'h30, 2, 0);
    repeat (30) @(negedge i_clk_sys);
    chk(32'(rx_ready), 32'hff, "multicast buffer kept");
    $display("test multicast done");
  endtask : t_multicast

  // Second frame queues behind the first and must come out whole
  task automatic t_queued();
    fork
      i_ser.send_frame(0, 8'h80, 4);
      i_ser.send_frame(1, 8'h80, 4);
    join
    // Port 1 request reaches port 7 one slot earlier, so its frame leads
    expect_frame(7, 1, 8'h80, 4, 0);
    expect_frame(7, 0, 8'h80, 4, 5);
    // Port 0 has reused buffer 0 by now; every port must still offer a buffer
    repeat (30) @(negedge i_clk_sys);
    chk(32'(rx_ready), 32'hff, "buffers not released");
    $display("test queued done");
  endtask : t_queued

  task automatic fw_read(input logic [11:0] a, input logic [9:0] want);
    @(negedge i_clk_sys);
    fw_rd = 1'b1;
    fw_addr = a;
    @(negedge i_clk_sys);
    fw_rd = 1'b0;
    // Answer stands for one cycle only, two edges after the request
    @(negedge i_clk_sys);
    chk(32'(fw_rvalid), 32'h1, "no read answer");
    chk(fw_rdata, 32'(want), "read word");
    chk(32'(fw_rpar), 32'(^want), "read parity");
  endtask : fw_read

  // Capture to firmware, swap, read back, write the last word of a buffer
  task automatic t_firmware();
    int t = 0;
    i_ser.send_frame(4, 8'h00, 3);
    while (fw_ready !== 1'b1 && t < 200) begin
      @(negedge i_clk_sys);
      t++;
    end
    chk(32'(fw_ready), 32'h1, "capture not ready");
    fw_swap = 1'b1;
    @(negedge i_clk_sys);
    fw_swap = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk(32'(fw_len), 32'h4, "frame length");
    for (int k = 0; k < 4; k++) begin
      fw_read(12'(k), 10'(word_of(4, 8'h00, 3, k)));
    end
    fw_wr = 1'b1;
    fw_addr = 12'h83f;
    fw_wdata = 32'h0000_02a5;
    @(negedge i_clk_sys);
    fw_wr = 1'b0;
    fw_read(12'h83f, 10'h2a5);
    $display("test firmware done");
  endtask : t_firmware

  initial begin
    do_reset(1'b0);
    t_unicast();
    t_multicast();
    t_queued();
    t_firmware();
    do_reset(1'b1);
    t_unicast(); // Mini buffers carry the same frame
    end_sim();
  end
endmodule : tb_top
